//--- verilog/ssx_pkg.sv
// shared constants for the skip and set instruction executor
package ssx_pkg;
   // operation codes presented by the decoder front end
   localparam logic [3:0] OP_NONE      = 4'h0;
   localparam logic [3:0] OP_RET_SKIP  = 4'h1;
   localparam logic [3:0] OP_SET_BIT   = 4'h2;
   localparam logic [3:0] OP_SET_CARRY = 4'h3;
   localparam logic [3:0] OP_CMP_IMM   = 4'h4;
   localparam logic [3:0] OP_EXT_FLAG  = 4'h5;
   localparam logic [3:0] OP_CONV_DONE = 4'h6;
   localparam logic [3:0] OP_PORT_TEST = 4'h7;
   localparam logic [3:0] OP_PIN_TEST  = 4'h8;
   localparam logic [3:0] OP_HALT_WAKE = 4'h9;
   // field positions
   localparam int EXT_EN_POS   = 0;
   localparam int CONV_EN_POS  = 2;
   localparam int POL_POS      = 2;
   // widths and reset values
   localparam int PC_W         = 12;
   localparam int SP_W         = 3;
   localparam int STK_DEPTH    = 8;
   localparam logic [PC_W-1:0] PC_RST = 12'h000;
   localparam logic [SP_W-1:0] SP_RST = 3'h7;
   // cycle counts
   localparam logic [1:0] CYC_RET_SKIP = 2'h2;
   localparam logic [1:0] CYC_CMP_IMM  = 2'h2;
endpackage

//--- verilog/ssx_stack.sv
// return address stack memory with registered read data
`timescale 1ns/1ns
module ssx_stack
   import ssx_pkg::*;
(
   input  wire logic            i_core_clk,
   input  wire logic            i_rst,
   input  wire logic            i_wr,
   input  wire logic [SP_W-1:0] i_wr_idx,
   input  wire logic [PC_W-1:0] i_wr_data,
   input  wire logic [SP_W-1:0] i_rd_idx,
   output logic      [PC_W-1:0] o_rd_data
);
   logic [PC_W-1:0] mem_q [STK_DEPTH];

   always_ff @(posedge i_core_clk) begin
      if (i_wr) begin
         mem_q[i_wr_idx] <= i_wr_data;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= PC_RST;
      end else begin
         o_rd_data <= mem_q[i_rd_idx];
      end
   end
endmodule

//--- verilog/ssx_exec.sv
// executor for return-skip, bit set, carry set, compare and flag skips
// Notes on behaviour
// - return-and-skip reloads pc from the stack, pops, skips; 2 cycles.
// - set-bit forces to one bit j (0 to 3) of the word at the ram pointer.
// - set-carry writes one to the carry flag in one cycle with no skip.
// - the 2-word, 2-cycle compare skips when acc equals the 4-bit imm.
// - ext enable 0: ext test skips on a set flag, clears it; else no-op.
// - conv enable 0: conv test skips on a set flag, clears it; else no-op.
// - the conv enable is bit 2 of the second interrupt control register.
// - the port test skips when the one-bit port reads 1.
// - the pin test polarity is bit 2 of the external input control reg.
`timescale 1ns/1ns
module ssx_exec
   import ssx_pkg::*;
(
   input  wire logic            i_core_clk,
   input  wire logic            i_rst,
   input  wire logic            i_op_valid,
   input  wire logic [3:0]      i_op,
   input  wire logic [1:0]      i_bit_sel,
   input  wire logic [3:0]      i_imm,
   input  wire logic            i_next_two_word,
   input  wire logic [3:0]      i_acc,
   input  wire logic [3:0]      i_mem_rdata,
   input  wire logic [7:0]      i_ram_pointer,
   input  wire logic [3:0]      i_irq_ctrl_reg_one,
   input  wire logic [3:0]      i_irq_ctrl_reg_two,
   input  wire logic [3:0]      i_ext_input_ctrl_reg,
   input  wire logic            i_ext_irq_set,
   input  wire logic            i_conv_done_set,
   input  wire logic            i_one_bit_port,
   input  wire logic            i_ext_irq_pin,
   input  wire logic            i_power_down_flag,
   input  wire logic            i_call,
   input  wire logic [PC_W-1:0] i_call_ret_addr,
   output logic                 o_busy,
   output logic                 o_skip_active,
   output logic                 o_pc_load,
   output logic      [PC_W-1:0] o_pc,
   output logic      [SP_W-1:0] o_return_stack_index,
   output logic                 o_carry_flag,
   output logic                 o_mem_we,
   output logic      [7:0]      o_mem_addr,
   output logic      [3:0]      o_mem_wdata,
   output logic                 o_ext_irq_req_flag,
   output logic                 o_conv_done_flag
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RET_WAIT,
      ST_CMP_WAIT
   } ssx_state_t;

   ssx_state_t      state_q;
   logic [1:0]      skip_cnt_q;
   logic [PC_W-1:0] stk_rd;
   logic            cmp_hit_q;
   logic            skipping;
   logic            run;
   logic            ext_en;
   logic            conv_en;
   logic            pol;
   logic            ext_clr;
   logic            conv_clr;
   logic            skip_req;
   logic [1:0]      skip_len;

   assign skipping = skip_cnt_q != 2'h0;
   assign run      = i_op_valid && !skipping && state_q == ST_IDLE;
   assign ext_en   = i_irq_ctrl_reg_one[EXT_EN_POS];
   assign conv_en  = i_irq_ctrl_reg_two[CONV_EN_POS];
   assign pol      = i_ext_input_ctrl_reg[POL_POS];
   assign ext_clr  = run && i_op == OP_EXT_FLAG && !ext_en
                     && o_ext_irq_req_flag;
   assign conv_clr = run && i_op == OP_CONV_DONE && !conv_en
                     && o_conv_done_flag;
   assign skip_len = i_next_two_word ? 2'h2 : 2'h1;

   ssx_stack u_stack (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_wr       (i_call),
      .i_wr_idx   (SP_W'(o_return_stack_index + 3'h1)),
      .i_wr_data  (i_call_ret_addr),
      .i_rd_idx   (o_return_stack_index),
      .o_rd_data  (stk_rd)
   );

   // single-cycle skip decisions
   always_comb begin
      skip_req = 1'b0;
      if (run) begin
         case (i_op)
            OP_EXT_FLAG:  skip_req = ext_clr;
            OP_CONV_DONE: skip_req = conv_clr;
            OP_PORT_TEST: skip_req = i_one_bit_port;
            OP_PIN_TEST:  skip_req = pol ? i_ext_irq_pin
                                         : !i_ext_irq_pin;
            OP_HALT_WAKE: skip_req = i_power_down_flag;
            default:      skip_req = 1'b0;
         endcase
      end
   end

   // multi-cycle sequencing
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q   <= ST_IDLE;
         cmp_hit_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (run && i_op == OP_RET_SKIP) begin
                  state_q <= ST_RET_WAIT;
               end else if (run && i_op == OP_CMP_IMM) begin
                  state_q   <= ST_CMP_WAIT;
                  cmp_hit_q <= i_acc == i_imm;
               end
            end
            ST_RET_WAIT: state_q <= ST_IDLE;
            ST_CMP_WAIT: state_q <= ST_IDLE;
            default:     state_q <= ST_IDLE;
         endcase
      end
   end

   // busy marks the second cycle of return-skip and compare
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_busy <= 1'b0;
      end else begin
         o_busy <= run && (i_op == OP_RET_SKIP
                           || i_op == OP_CMP_IMM);
      end
   end

   // skip window counter, in instruction words
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         skip_cnt_q <= 2'h0;
      end else if (skip_req) begin
         skip_cnt_q <= skip_len;
      end else if (state_q == ST_RET_WAIT) begin
         skip_cnt_q <= skip_len;
      end else if (state_q == ST_CMP_WAIT && cmp_hit_q) begin
         skip_cnt_q <= skip_len;
      end else if (skipping && i_op_valid) begin
         skip_cnt_q <= skip_cnt_q - 2'h1;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_skip_active <= 1'b0;
      end else begin
         o_skip_active <= skip_req || (state_q == ST_RET_WAIT)
                          || (state_q == ST_CMP_WAIT && cmp_hit_q);
      end
   end

   // program counter reload and stack index
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pc_load            <= 1'b0;
         o_pc                 <= PC_RST;
         o_return_stack_index <= SP_RST;
      end else begin
         o_pc_load <= 1'b0;
         if (i_call) begin
            o_return_stack_index <= o_return_stack_index + 3'h1;
         end else if (state_q == ST_RET_WAIT) begin
            o_pc_load            <= 1'b1;
            o_pc                 <= stk_rd;
            o_return_stack_index <= o_return_stack_index - 3'h1;
         end
      end
   end

   // carry flag
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_carry_flag <= 1'b0;
      end else if (run && i_op == OP_SET_CARRY) begin
         o_carry_flag <= 1'b1;
      end
   end

   // memory bit set
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mem_we    <= 1'b0;
         o_mem_addr  <= 8'h00;
         o_mem_wdata <= 4'h0;
      end else begin
         o_mem_we <= run && i_op == OP_SET_BIT;
         if (run && i_op == OP_SET_BIT) begin
            o_mem_addr  <= i_ram_pointer;
            o_mem_wdata <= i_mem_rdata | (4'h1 << i_bit_sel);
         end
      end
   end

   // request flags: a set arriving with a clear wins
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ext_irq_req_flag <= 1'b0;
         o_conv_done_flag   <= 1'b0;
      end else begin
         if (i_ext_irq_set) begin
            o_ext_irq_req_flag <= 1'b1;
         end else if (ext_clr) begin
            o_ext_irq_req_flag <= 1'b0;
         end
         if (i_conv_done_set) begin
            o_conv_done_flag <= 1'b1;
         end else if (conv_clr) begin
            o_conv_done_flag <= 1'b0;
         end
      end
   end
endmodule

//--- verif/ssx_exec_props.sv
// assertion checker for the skip and set executor
`timescale 1ns/1ns
module ssx_exec_props
   import ssx_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   input  wire logic       i_op_valid,
   input  wire logic [3:0] i_op,
   input  wire logic [1:0] i_bit_sel,
   input  wire logic [3:0] i_mem_rdata,
   input  wire logic [7:0] i_ram_pointer,
   input  wire logic [3:0] i_irq_ctrl_reg_one,
   input  wire logic [3:0] i_irq_ctrl_reg_two,
   input  wire logic       i_ext_irq_set,
   input  wire logic       o_busy,
   input  wire logic       o_skip_active,
   input  wire logic       o_pc_load,
   input  wire logic       o_carry_flag,
   input  wire logic       o_mem_we,
   input  wire logic [7:0] o_mem_addr,
   input  wire logic [3:0] o_mem_wdata,
   input  wire logic       o_ext_irq_req_flag,
   input  wire logic       o_conv_done_flag
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   AST_CARRY_CAUSE: assert property (
      $rose(o_carry_flag) |-> $past(i_op_valid && i_op == OP_SET_CARRY))
      else $error("carry rose without set-carry");
   AST_CARRY_HOLD: assert property (
      o_carry_flag |=> o_carry_flag) else $error("carry lost");
   AST_SET_BIT: assert property (
      o_mem_we |-> o_mem_addr == $past(i_ram_pointer) && o_mem_wdata ==
      ($past(i_mem_rdata) | (4'h1 << $past(i_bit_sel))))
      else $error("bad set-bit write");
   AST_EXT_CLR: assert property (
      $fell(o_ext_irq_req_flag) |-> o_skip_active && $past(i_op_valid &&
      i_op == OP_EXT_FLAG && !i_irq_ctrl_reg_one[EXT_EN_POS]))
      else $error("ext flag cleared wrongly");
   AST_CONV_CLR: assert property (
      $fell(o_conv_done_flag) |-> o_skip_active && $past(i_op_valid &&
      i_op == OP_CONV_DONE && !i_irq_ctrl_reg_two[CONV_EN_POS]))
      else $error("conv flag cleared wrongly");
   AST_TWO_CYC: assert property (
      $rose(o_busy) |-> $past(i_op_valid && (i_op == OP_CMP_IMM ||
      i_op == OP_RET_SKIP)) ##1 !o_busy) else $error("bad busy cycle");
   AST_RET_LOAD: assert property (
      o_pc_load |-> $past(o_busy) && o_skip_active)
      else $error("pc load without skip");
   AST_EXT_SET: assert property (
      i_ext_irq_set |=> o_ext_irq_req_flag) else $error("ext flag not set");
endmodule

bind ssx_exec ssx_exec_props u_props (.i_core_clk, .i_rst, .i_op_valid,
   .i_op, .i_bit_sel, .i_mem_rdata, .i_ram_pointer, .i_irq_ctrl_reg_one,
   .i_irq_ctrl_reg_two, .i_ext_irq_set, .o_busy, .o_skip_active, .o_pc_load,
   .o_carry_flag, .o_mem_we, .o_mem_addr, .o_mem_wdata, .o_ext_irq_req_flag,
   .o_conv_done_flag);

//--- verif/tb.sv
// self-checking bench for the skip and set executor
`timescale 1ns/1ns
module tb
   import ssx_pkg::*;
;
`define CHK(n,e,g) begin n_compared++; if ((g) !== (e)) begin errors++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end
   logic i_core_clk = '0, i_rst = '1, i_op_valid = '0, i_next_two_word = '0;
   logic i_ext_irq_set = '0, i_conv_done_set = '0, i_one_bit_port = '0;
   logic i_ext_irq_pin = '0, i_power_down_flag = '0, i_call = '0;
   logic [1:0] i_bit_sel = '0;
   logic [3:0] i_op = '0, i_imm = '0, i_acc = '0, i_mem_rdata = '0;
   logic [3:0] i_irq_ctrl_reg_one = '0, i_irq_ctrl_reg_two = '0;
   logic [3:0] i_ext_input_ctrl_reg = '0;
   logic [7:0] i_ram_pointer = 8'h3C;
   logic [PC_W-1:0] i_call_ret_addr = 12'h5A3, o_pc, pcv;
   logic o_busy, o_skip_active, o_pc_load, o_carry_flag, o_mem_we, seen, ld;
   logic o_ext_irq_req_flag, o_conv_done_flag;
   logic [SP_W-1:0] o_return_stack_index;
   logic [7:0] o_mem_addr;
   logic [3:0] o_mem_wdata;
   logic [3:0] acc_t [4] = '{4'h0, 4'h5, 4'hF, 4'h7};
   logic [3:0] imm_t [4] = '{4'h0, 4'h4, 4'hF, 4'h7};
   int errors = 0, n_compared = 0;
   ssx_exec i_dut (.*);
   always #5 i_core_clk = ~i_core_clk;
   task step;
      @(posedge i_core_clk);
      #1;
   endtask
   task do_op(input logic [3:0] op);
      i_op = op;
      i_op_valid = 1'h1;
      step;
      i_op_valid = 1'h0;
   endtask
   // watch for the skip, then feed set-bit words that must be swallowed
   task probe(input logic exp, input int nv);
      seen = 1'h0;
      ld = 1'h0;
      repeat (3) begin
         seen |= o_skip_active;
         if (o_pc_load) pcv = o_pc;
         ld |= o_pc_load;
         step;
      end
      `CHK("skip", exp, seen)
      repeat (nv) begin
         do_op(OP_SET_BIT);
         `CHK("skipped word", 1'h0, o_mem_we)
      end
      do_op(OP_SET_BIT);
      `CHK("next word", 1'h1, o_mem_we)
   endtask
   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge i_core_clk);
      #1 i_rst = 1'h0;
      `CHK("index reset", SP_RST, o_return_stack_index)
      `CHK("carry reset", 1'h0, o_carry_flag)
      do_op(OP_SET_CARRY);
      `CHK("carry", 1'h1, o_carry_flag)
      probe(1'h0, 0);
      for (int j = 0; j < 4; j++) begin
         i_bit_sel = j[1:0];
         i_mem_rdata = 4'h5;
         do_op(OP_SET_BIT);
         `CHK("wdata", 4'h5 | (4'h1 << j), o_mem_wdata)
         `CHK("addr", 8'h3C, o_mem_addr)
      end
      $display("carry and set-bit tests done");
      for (int k = 0; k < 4; k++) begin
         i_acc = acc_t[k];
         i_imm = imm_t[k];
         i_next_two_word = k[0];
         do_op(OP_CMP_IMM);
         `CHK("busy", 1'h1, o_busy)
         probe(acc_t[k] == imm_t[k],
               (acc_t[k] == imm_t[k]) ? 1 + k[0] : 0);
      end
      i_next_two_word = 1'h0;
      $display("compare test done");
      for (int en = 1; en >= 0; en--) begin
         i_irq_ctrl_reg_one = en ? 4'h1 : 4'hE;
         i_irq_ctrl_reg_two = en ? 4'h4 : 4'hB;
         i_ext_irq_set = 1'h1;
         i_conv_done_set = 1'h1;
         step;
         i_ext_irq_set = 1'h0;
         i_conv_done_set = 1'h0;
         do_op(OP_EXT_FLAG);
         probe(!en, !en);
         `CHK("ext flag", en[0], o_ext_irq_req_flag)
         do_op(OP_CONV_DONE);
         probe(!en, !en);
         `CHK("conv flag", en[0], o_conv_done_flag)
      end
      do_op(OP_EXT_FLAG);
      probe(1'h0, 0);
      do_op(OP_CONV_DONE);
      probe(1'h0, 0);
      $display("flag test done");
      for (int k = 0; k < 4; k++) begin
         i_one_bit_port = k[0];
         i_ext_irq_pin = k[0];
         i_power_down_flag = k[0];
         i_ext_input_ctrl_reg = k[1] ? 4'h4 : 4'hB;
         do_op(OP_PORT_TEST);
         probe(k[0], k[0]);
         do_op(OP_PIN_TEST);
         probe(k[0] == k[1], k[0] == k[1]);
         do_op(OP_HALT_WAKE);
         probe(k[0], k[0]);
      end
      $display("level test done");
      i_call = 1'h1;
      step;
      i_call = 1'h0;
      `CHK("push index", 3'h0, o_return_stack_index)
      step;
      do_op(OP_RET_SKIP);
      `CHK("ret busy", 1'h1, o_busy)
      probe(1'h1, 1);
      `CHK("pc load", 1'h1, ld)
      `CHK("pc", 12'h5A3, pcv)
      `CHK("pop index", SP_RST, o_return_stack_index)
      $display("return test done");
      stop_test;
   end
endmodule
